// ===== hdl/enc_consts.vh
// Purpose: shared offsets, fields, reset values and timing figures
// Assumes: included by the encoder and commutation output logic
// Notes: byte offsets on a 32-bit AHB-Lite register bus
`ifndef ENC_CONSTS_VH
`define ENC_CONSTS_VH

// Clock and startup timing
`define CLK_PERIOD_NS 24'h000005
`define PWRUP_UNDEF_NS 24'h002710
`define DELAY_PHASE_NS 24'h002710

// Register byte offsets
`define ADDR_CTRL 8'h00
`define ADDR_STEP 8'h04
`define ADDR_HYST 8'h08
`define ADDR_STAT 8'h0C
`define ADDR_WANG 8'h10

// Control fields
`define CTRL_POLE_LSB 0
`define CTRL_IDX_LSB 4
`define CTRL_ROUTE_BIT 6
`define CTRL_RES_LSB 8

// Status fields
`define STAT_DIR_BIT 0
`define STAT_CATCH_BIT 1
`define STAT_TRACK_BIT 2
`define STAT_START_BIT 3

// Reset values and limits
`define POLE_RST 4'h0
`define IDX_RST 2'h0
`define RES_RST 4'hC
`define RES_MIN 4'h2
`define RES_MAX 4'hE
`define STEP_RST 16'h0000
`define HYST_RST 6'h00

`endif

// ===== hdl/angle_window_filter.v
// Purpose: angle hysteresis window with moving head and direction flag
// Assumes: angle samples and restart come from the hclk domain
// Notes: output equals the head of the window
`include "enc_consts.vh"

module angle_window_filter (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Control
    input wire restart,
    input wire sample,
    input wire [13:0] angle,
    input wire [5:0] width,
    // Result
    output reg [13:0] filt_angle,
    output reg dir
);

    reg fresh_r;
    wire [13:0] delta;
    wire signed [14:0] delta_s;
    wire signed [14:0] width_s;

    // Modular difference, so the window works across the 0/360 seam
    assign delta = angle - filt_angle;
    assign delta_s = {delta[13], delta};
    assign width_s = {9'h000, width};

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            filt_angle <= 14'h0000;
            dir <= 1'b0;
            fresh_r <= 1'b1;
        end else if (restart) begin
            dir <= 1'b0;
            fresh_r <= 1'b1;
        end else if (sample) begin
            if (fresh_r) begin
                // Head at first angle, window trails it
                filt_angle <= angle;
                fresh_r <= 1'b0;
            end else if (!dir) begin
                if (delta_s > 15'sh0000) begin
                    filt_angle <= angle;
                end else if (delta_s < -width_s) begin
                    filt_angle <= angle;
                    dir <= 1'b1;
                end
            end else begin
                if (delta_s < 15'sh0000) begin
                    filt_angle <= angle;
                end else if (delta_s > width_s) begin
                    filt_angle <= angle;
                    dir <= 1'b0;
                end
            end
            // Inside the window the head stays put
        end
    end

endmodule

// ===== hdl/encoder_commutation_output.v
// Purpose: quadrature/index encoder and three-phase commutation outputs
// Assumes: angle_in, angle_valid and reinit come from hclk logic
// Notes: registers reached over AHB-Lite, reads take one wait state
`include "enc_consts.vh"

module encoder_commutation_output #(
    parameter [23:0] UNDEF_CYC = `PWRUP_UNDEF_NS / `CLK_PERIOD_NS,
    parameter [23:0] DELAY_CYC = `DELAY_PHASE_NS / `CLK_PERIOD_NS
) (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // Angle source
    input wire [13:0] angle_in,
    input wire angle_valid,
    input wire reinit,
    // Encoder outputs
    output reg enc_a,
    output reg enc_b,
    output reg enc_i,
    // Commutation outputs
    output reg comm_u,
    output reg comm_v,
    output reg comm_w
);

    ////////////////////////////////////////////////////////////////////
    // Constants and helpers

    localparam [3:0] S_UNDEF = 4'b0001;
    localparam [3:0] S_DELAY = 4'b0010;
    localparam [3:0] S_CATCH = 4'b0100;
    localparam [3:0] S_TRACK = 4'b1000;

    localparam [23:0] UNDEF_LAST = UNDEF_CYC - 24'h000001;
    localparam [23:0] DELAY_LAST = DELAY_CYC - 24'h000001;

    // Keep quadrature resolution in the supported span
    function [3:0] clamp_res;
        input [3:0] n;
        begin
            if (n < `RES_MIN)
                clamp_res = `RES_MIN;
            else if (n > `RES_MAX)
                clamp_res = `RES_MAX;
            else
                clamp_res = n;
        end
    endfunction

    // Mask of valid quadrature state bits for n-bit resolution
    function [13:0] quad_mask;
        input [3:0] n;
        begin
            quad_mask = ~(14'h3FFF << n);
        end
    endfunction

    // Quadrature state count of a 14-bit angle
    function [13:0] quad_pos;
        input [13:0] a;
        input [3:0] n;
        begin
            quad_pos = a >> (4'hE - n);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Registers

    reg [3:0] pole_r;
    reg [1:0] idxw_r;
    reg route_r;
    reg [3:0] res_r;
    reg [15:0] step_r;
    reg [5:0] hyst_r;

    reg [3:0] state_r;
    reg [23:0] tmr_r;
    reg [13:0] pos_r;
    reg [15:0] scnt_r;
    reg [13:0] raw_r;

    reg wr_pend_r;
    reg [7:0] wr_addr_r;
    reg rd_pend_r;
    reg [7:0] rd_addr_r;
    reg [31:0] rd_mux;

    wire [13:0] filt_angle;
    wire turn_direction_flag;

    ////////////////////////////////////////////////////////////////////
    // Hysteresis window

    angle_window_filter u_filter (
        .clk(hclk),
        .rst_n(hresetn),
        .restart(reinit),
        .sample(angle_valid),
        .angle(angle_in),
        .width(hyst_r),
        .filt_angle(filt_angle),
        .dir(turn_direction_flag)
    );

    ////////////////////////////////////////////////////////////////////
    // AHB-Lite slave

    wire addr_ok;
    wire word_ok;

    assign addr_ok = hsel & htrans[1] & hready;
    // Only whole-word writes are honoured
    assign word_ok = (hsize == 3'h2);

    always @* begin
        rd_mux = 32'h00000000;
        case (rd_addr_r)
            `ADDR_CTRL: begin
                rd_mux[`CTRL_POLE_LSB +: 4] = pole_r;
                rd_mux[`CTRL_IDX_LSB +: 2] = idxw_r;
                rd_mux[`CTRL_ROUTE_BIT] = route_r;
                rd_mux[`CTRL_RES_LSB +: 4] = res_r;
            end
            `ADDR_STEP: begin
                rd_mux[15:0] = step_r;
            end
            `ADDR_HYST: begin
                rd_mux[5:0] = hyst_r;
            end
            `ADDR_STAT: begin
                rd_mux[`STAT_DIR_BIT] = turn_direction_flag;
                rd_mux[`STAT_CATCH_BIT] = (state_r == S_CATCH);
                rd_mux[`STAT_TRACK_BIT] = (state_r == S_TRACK);
                rd_mux[`STAT_START_BIT] = (state_r == S_UNDEF) |
                                          (state_r == S_DELAY);
            end
            `ADDR_WANG: begin
                rd_mux[11:0] = filt_angle[13:2];
            end
            default: begin
                rd_mux = 32'h00000000;
            end
        endcase
    end

    // Reads wait one cycle, so they always see a completed write
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            rd_pend_r <= 1'b0;
            rd_addr_r <= 8'h00;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
            wr_pend_r <= addr_ok & hwrite & word_ok;
            rd_pend_r <= addr_ok & ~hwrite;
            if (addr_ok) begin
                wr_addr_r <= haddr[7:0];
                rd_addr_r <= haddr[7:0];
            end
            if (addr_ok & ~hwrite) begin
                hreadyout <= 1'b0;
            end else begin
                hreadyout <= 1'b1;
            end
            if (rd_pend_r) begin
                hrdata <= rd_mux;
            end
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pole_r <= `POLE_RST;
            idxw_r <= `IDX_RST;
            route_r <= 1'b0;
            res_r <= `RES_RST;
            step_r <= `STEP_RST;
            hyst_r <= `HYST_RST;
        end else if (wr_pend_r) begin
            case (wr_addr_r)
                `ADDR_CTRL: begin
                    pole_r <= hwdata[`CTRL_POLE_LSB +: 4];
                    idxw_r <= hwdata[`CTRL_IDX_LSB +: 2];
                    route_r <= hwdata[`CTRL_ROUTE_BIT];
                    res_r <= clamp_res(hwdata[`CTRL_RES_LSB +: 4]);
                end
                `ADDR_STEP: begin
                    step_r <= hwdata[15:0];
                end
                `ADDR_HYST: begin
                    hyst_r <= hwdata[5:0];
                end
                default: begin
                    step_r <= step_r;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Angle selection and quadrature stepping

    wire [13:0] sel_angle;
    wire [13:0] mask;
    wire [13:0] target;
    wire [13:0] diff;
    wire [13:0] half;
    wire match;
    wire step_down;
    wire limit_on;
    wire tick;
    wire stepping;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            raw_r <= 14'h0000;
        end else if (angle_valid) begin
            raw_r <= angle_in;
        end
    end

    // Raw is latched so both sources share one cycle of latency
    assign sel_angle = route_r ? filt_angle : raw_r;
    assign mask = quad_mask(res_r);
    assign target = quad_pos(sel_angle, res_r);
    assign diff = (target - pos_r) & mask;
    assign half = (mask >> 1) + 14'h0001;
    assign match = (diff == 14'h0000);
    assign step_down = |(diff & half);
    assign limit_on = (step_r != 16'h0000);
    assign tick = (scnt_r >= step_r - 16'h0001);
    assign stepping = (state_r == S_CATCH) | (state_r == S_TRACK);

    // Interval timer runs on hclk only, not on the sample rate
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            scnt_r <= 16'h0000;
        end else if (!stepping || !limit_on || tick) begin
            scnt_r <= 16'h0000;
        end else begin
            scnt_r <= scnt_r + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Startup sequence

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= S_UNDEF;
            tmr_r <= 24'h000000;
            pos_r <= 14'h0000;
        end else if (reinit) begin
            state_r <= S_UNDEF;
            tmr_r <= 24'h000000;
            pos_r <= 14'h0000;
        end else begin
            case (state_r)
                S_UNDEF: begin
                    pos_r <= 14'h0000;
                    if (tmr_r >= UNDEF_LAST) begin
                        tmr_r <= 24'h000000;
                        state_r <= S_DELAY;
                    end else begin
                        tmr_r <= tmr_r + 24'h000001;
                    end
                end
                S_DELAY: begin
                    pos_r <= 14'h0000;
                    if (tmr_r >= DELAY_LAST) begin
                        tmr_r <= 24'h000000;
                        state_r <= S_CATCH;
                    end else begin
                        tmr_r <= tmr_r + 24'h000001;
                    end
                end
                S_CATCH: begin
                    if (!limit_on) begin
                        pos_r <= target;
                        state_r <= S_TRACK;
                    end else if (match) begin
                        state_r <= S_TRACK;
                    end else if (tick) begin
                        if (step_down)
                            pos_r <= (pos_r - 14'h0001) & mask;
                        else
                            pos_r <= (pos_r + 14'h0001) & mask;
                    end
                end
                S_TRACK: begin
                    if (!limit_on) begin
                        pos_r <= target;
                    end else if (!match && tick) begin
                        if (step_down)
                            pos_r <= (pos_r - 14'h0001) & mask;
                        else
                            pos_r <= (pos_r + 14'h0001) & mask;
                    end
                end
                default: begin
                    state_r <= S_UNDEF;
                    tmr_r <= 24'h000000;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Commutation decode

    wire [18:0] elec_full;
    wire [13:0] elec;
    wire [16:0] sect_full;
    wire [2:0] sector;

    // Pole count is selector plus one
    assign elec_full = sel_angle * ({1'b0, pole_r} + 5'h01);
    assign elec = elec_full[13:0];
    assign sect_full = elec * 3'h6;
    assign sector = sect_full[16:14];

    ////////////////////////////////////////////////////////////////////
    // Output flops

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enc_a <= 1'b0;
            enc_b <= 1'b0;
            enc_i <= 1'b0;
            comm_u <= 1'b0;
            comm_v <= 1'b0;
            comm_w <= 1'b0;
        end else if (state_r == S_UNDEF) begin
            // Driven low; receiver must ignore them here
            enc_a <= 1'b0;
            enc_b <= 1'b0;
            enc_i <= 1'b0;
            comm_u <= 1'b0;
            comm_v <= 1'b0;
            comm_w <= 1'b0;
        end else begin
            enc_a <= pos_r[1];
            enc_b <= pos_r[1] ^ pos_r[0];
            // Index spans one to four states from zero
            enc_i <= (pos_r <= {12'h000, idxw_r});
            comm_u <= (sector < 3'h3);
            comm_v <= (sector >= 3'h2) & (sector < 3'h5);
            comm_w <= (sector >= 3'h4) | (sector == 3'h0);
        end
    end

endmodule

// ===== sim/quad_receiver.sv
// Purpose: quadrature receiver that counts steps from the A/B lines
// Assumes: lines sampled on the block clock
// Notes: illegal two-state jumps are counted, not decoded
module quad_receiver (
    // Clock and enable
    input wire clk,
    input wire arm,
    // Encoder lines
    input wire a,
    input wire b,
    // Decoded position
    output int count,
    output int bad
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] last;
    function automatic logic [1:0] idx(input logic [1:0] ab);
        case (ab)
            2'h0: return 2'h0;
            2'h1: return 2'h1;
            2'h3: return 2'h2;
            default: return 2'h3;
        endcase
    endfunction
    always @(posedge clk) begin
        last <= {a, b};
        if (!arm) begin
            count <= 0;
            bad <= 0;
        end else if ({a, b} != last) begin
            case (idx({a, b}) - idx(last))
                2'h1: count <= count + 1;
                2'h3: count <= count - 1;
                default: bad <= bad + 1;
            endcase
        end
    end
endmodule

// ===== sim/enc_out_props.sv
// Purpose: port-level checks of startup, bus timing and commutation
// Assumes: one clock domain, reset active low
// Notes: cycle counter restarts on reset and on reinit
module enc_out_props #(
    parameter [23:0] UNDEF_CYC = 24'h0007D0,
    parameter [23:0] DELAY_CYC = 24'h0007D0
) (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // Bus
    input wire hsel,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    // Angle control
    input wire reinit,
    // Outputs
    input wire enc_a,
    input wire enc_b,
    input wire enc_i,
    input wire comm_u,
    input wire comm_v,
    input wire comm_w
);
    localparam [23:0] DONE = UNDEF_CYC + DELAY_CYC + 24'h000040;
    reg [23:0] cyc_r;
    wire [23:0] cyc_nxt = reinit ? 24'h000000 :
        (cyc_r == DONE) ? cyc_r : cyc_r + 24'h000001;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            cyc_r <= 24'h000000;
        else
            cyc_r <= cyc_nxt;
    end
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Margins of two cycles absorb the output register lag
    a_undef_low: assert property (
        cyc_r > 24'h000001 && cyc_r < UNDEF_CYC - 24'h000001
        |-> !(enc_a || enc_b || enc_i))
        else $error("encoder lines not low while undefined");
    a_delay_zero: assert property (
        cyc_r == UNDEF_CYC + (DELAY_CYC >> 1)
        |-> enc_i && !enc_a && !enc_b)
        else $error("delay phase does not show zero angle");
    a_comm_six: assert property (
        cyc_r == DONE |-> (comm_u || comm_v || comm_w)
        && !(comm_u && comm_v && comm_w))
        else $error("commutation in an invalid state");
    a_read_wait: assert property (
        hsel && htrans[1] && !hwrite && hready |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_write_nowait: assert property (
        hsel && htrans[1] && hwrite && hready |=> hreadyout)
        else $error("write was stalled");
    a_rdata_hold: assert property (
        !$stable(hrdata) |-> !$past(hreadyout))
        else $error("read data changed outside a read");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    a_reset_idle: assert property (
        $rose(hresetn) |-> hreadyout && !enc_i && !enc_a)
        else $error("outputs not idle after reset");
endmodule
bind encoder_commutation_output enc_out_props #(
    .UNDEF_CYC(UNDEF_CYC), .DELAY_CYC(DELAY_CYC)) i_props (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .reinit(reinit),
    .enc_a(enc_a), .enc_b(enc_b), .enc_i(enc_i),
    .comm_u(comm_u), .comm_v(comm_v), .comm_w(comm_w));

// ===== sim/testbench.sv
// Purpose: self-checking bench for encoder and commutation outputs
// Assumes: startup counts shortened to eight cycles each
// Notes: an angle sample is pulsed every fourth cycle throughout
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam [23:0] DLY = 24'h000008;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
    logic [1:0] htrans = 2'h0, ph = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [13:0] angle_in = 14'h3FC0;
    logic angle_valid = 1'b0, reinit = 1'b0, arm = 1'b0;
    wire [31:0] hrdata;
    wire hreadyout, hresp, enc_a, enc_b, enc_i, comm_u, comm_v, comm_w;
    int rx_cnt, rx_bad, n_fail = 0, n_compared = 0;
    always #2.5 hclk = ~hclk;
    always @(posedge hclk) begin
        ph <= ph + 2'h1;
        angle_valid <= (ph == 2'h3);
    end
    encoder_commutation_output #(.UNDEF_CYC(DLY), .DELAY_CYC(DLY)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .angle_in(angle_in), .angle_valid(angle_valid),
        .reinit(reinit), .enc_a(enc_a), .enc_b(enc_b), .enc_i(enc_i),
        .comm_u(comm_u), .comm_v(comm_v), .comm_w(comm_w));
    quad_receiver i_rx (.clk(hclk), .arm(arm), .a(enc_a), .b(enc_b),
        .count(rx_cnt), .bad(rx_bad));
    ////////////////////////////////////////////////////////////
    task automatic conclude;
        if (n_fail == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask
    task automatic bound(input int k, input int lim);
        if (k >= lim) begin
            chk("wait bound", lim, k);
            conclude;
        end
    endtask
    task automatic wait_rdy;
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 40);
        bound(k, 40);
    endtask
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        q = hrdata;
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a,
        input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask
    task automatic set_ang(input int a);
        angle_in <= a[13:0];
        repeat (8) @(posedge hclk);
    endtask
    function automatic logic [1:0] quad_of(input int a);
        int p;
        p = a >> 2;
        return {p[1], p[1] ^ p[0]};
    endfunction
    function automatic logic [2:0] comm_of(input int a, input int n);
        int s;
        s = ((a * n) % 16384) * 6 >> 14;
        return {s <= 2, s >= 2 && s <= 4, s >= 4 || s == 0};
    endfunction
    ////////////////////////////////////////////////////////////
    task automatic t_start;
        int k;
        k = 0;
        xfer(1'b1, 8'h04, 32'h3);
        while (enc_i !== 1'b1 && k < 60) begin
            @(posedge hclk);
            k++;
        end
        bound(k, 60);
        chk("delay state", 32'h4, {enc_i, enc_a, enc_b});
        arm <= 1'b1;
        while (rx_cnt != -16 && k < 400) begin
            @(posedge hclk);
            k++;
        end
        bound(k, 400);
        chk("skipped states", 32'h0, rx_bad);
        rd_chk("status", 8'h0C, 32'h4);
        chk("final count", 32'hFFFFFFF0, rx_cnt);
        rd_chk("ctrl reset", 8'h00, 32'hC00);
        rd_chk("step", 8'h04, 32'h3);
        rd_chk("window reset", 8'h08, 32'h0);
        hsize <= 3'h0;
        xfer(1'b1, 8'h08, 32'h3F);
        hsize <= 3'h2;
        rd_chk("narrow write", 8'h08, 32'h0);
        rd_chk("unmapped", 8'h14, 32'h0);
    endtask
    task automatic t_index;
        xfer(1'b1, 8'h04, 32'h0);
        for (int w = 0; w < 4; w++) begin
            xfer(1'b1, 8'h00, 32'hC00 | (w << 4));
            set_ang(w * 4);
            chk("index high", 32'h1, enc_i);
            chk("quad state", quad_of(w * 4), {enc_a, enc_b});
            set_ang(w * 4 + 4);
            chk("index low", 32'h0, enc_i);
        end
    endtask
    task automatic t_comm;
        int a;
        for (int n = 1; n <= 16; n++) begin
            xfer(1'b1, 8'h00, 32'hC00 | (n - 1));
            for (int k = 0; k < 3; k++) begin
                a = (n * 1237 + k * 5461) % 16384;
                set_ang(a);
                chk("phases", comm_of(a, n), {comm_u, comm_v, comm_w});
            end
        end
    endtask
    task automatic t_hyst;
        // Walks across the first sector boundary near 2731
        int ang[6] = '{2700, 2728, 2736, 2730, 2727, 2731};
        int fil[6] = '{0, 2728, 2736, 2736, 2727, 2727};
        int nb;
        xfer(1'b1, 8'h08, 32'h8);
        // Settle on the start angle before limiting, else a long walk
        set_ang(ang[0]);
        xfer(1'b1, 8'h04, 32'h1);
        xfer(1'b1, 8'h00, 32'hC40);
        nb = rx_bad;
        for (int k = 0; k < 6; k++) begin
            set_ang(ang[k]);
            if (k > 0) begin
                rd_chk("filtered", 8'h10, fil[k] >> 2);
                rd_chk("direction", 8'h0C, 32'h4 | (k > 3));
                chk("routed quad", quad_of(fil[k]), {enc_a, enc_b});
                chk("routed phases", comm_of(fil[k], 1),
                    {comm_u, comm_v, comm_w});
            end
        end
        chk("gray steps", nb, rx_bad);
    endtask
    task automatic t_reinit;
        int k;
        k = 0;
        xfer(1'b1, 8'h04, 32'h0);
        reinit <= 1'b1;
        @(posedge hclk);
        reinit <= 1'b0;
        rd_chk("restart status", 8'h0C, 32'h8);
        while (enc_i !== 1'b1 && k < 60) begin
            @(posedge hclk);
            k++;
        end
        bound(k, 60);
        k = 0;
        while (enc_i !== 1'b0 && k < 60) begin
            @(posedge hclk);
            k++;
        end
        chk("jump time", 32'h1, k <= DLY + 2);
        chk("jump state", quad_of(2731), {enc_a, enc_b});
    endtask
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        t_start;
        t_index;
        t_comm;
        t_hyst;
        t_reinit;
        conclude;
    end
endmodule
